// ---- dv/operator_model.sv ----
// Operator model that presses the local reset push-button.
`timescale 1ns/1ps
module operator_model #(
  parameter int TICK = 2
) (
  input  wire logic clock_i,
  output logic      button_o
);
  initial button_o = 1'b0;
  // Holds the button for ms milliseconds, then leaves one second before the next press.
  task automatic hold(input int ms);
    @(posedge clock_i) button_o <= 1'b1;
    repeat (ms * TICK) @(posedge clock_i);
    button_o <= 1'b0;
    repeat (1000 * TICK) @(posedge clock_i);
  endtask
endmodule

// ---- dv/tb.sv ----
// Self-checking testbench for the push-button menu block.
`timescale 1ns/1ps
module tb;
  localparam int T = 2;
  logic        clock_i, rst_i, awvalid, wvalid, bready, arvalid, rready, button, remote;
  logic        awready, wready, bvalid, arready, rvalid, red, green, shut, rec, lock, light;
  logic        red_q, green_q;
  logic [7:0]  awaddr, araddr, env;
  logic [2:0]  imm;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, bs, rs, interm;
  int          err_total, check_count, reds, greens, shuts, recs, n, i;
  menu_lockout #(.TICK_CYCLES(T)) i_menu_lockout (
    .clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .button_i(button), .remote_reset_i(remote), .running_i(1'b1), .flame_i(env[0]),
    .flame_loss_i(env[1]), .oil_valve_open_i(env[2]), .heater_fitted_i(env[3]),
    .preheating_i(env[4]), .light_standby_i(env[5]), .light_prepurge_i(env[6]),
    .light_preheat_i(env[7]), .fan_fault_i(imm[0]), .valve_drive_fault_i(imm[1]),
    .nvm_error_i(imm[2]), .led_red_o(red), .led_green_o(green), .shutdown_req_o(shut),
    .recycle_restore_o(rec), .restart_req_o(), .lockout_o(lock), .pb_fail_o(),
    .light_diag_en_o(light), .interm_mode_o(interm));
  operator_model #(.TICK(T)) i_operator_model (.clock_i(clock_i), .button_o(button));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // Counts LED turn-on edges and request pulses for the checks below.
  always @(posedge clock_i) begin
    red_q <= red;
    green_q <= green;
    if (red && !red_q) reds++;
    if (green && !green_q) greens++;
    if (shut) shuts++;
    if (rec) recs++;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t: saw %h, want %h", $time, s, e);
    end
  endtask
  task automatic tmo;
    err_total++;
    end_of_test;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bs = bresp;
    bready <= 1'b0;
    if (n == 40) tmo;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clock_i);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    {rd, rs} = {rdata, rresp};
    rready <= 1'b0;
    if (n == 40) tmo;
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, remote, red_q, green_q} = 8'h00;
    {awaddr, araddr, env, imm, wdata} = 0;
    rst_i = 1'b1;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    rdr(8'h00);
    chk(rd, 32'h00000004);
    chk(interm, 2'h2);
    rdr(8'h0C);
    chk(rs, 2'h3);
    wr(8'h04, 32'h00000000);
    chk(bs, 2'h0);
    wr(8'h00, 32'h00000002);
    chk(interm, 2'h2);
    i_operator_model.hold(6000);
    chk(reds, 2);
    chk(shuts, 1);
    chk(recs, 1);
    chk(greens, 0);
    chk(interm, 2'h1);
    wr(8'h00, 32'h00000003);
    chk(light, 1'b1);
    i_operator_model.hold(16000);
    chk(greens, 2);
    repeat (3) i_operator_model.hold(500);
    chk(greens, 5);
    repeat (11500 * T) @(posedge clock_i);
    chk(greens, 7);
    chk(light, 1'b0);
    for (i = 0; i < 3; i++) begin
      imm <= 3'b001 << i;
      repeat (3) @(posedge clock_i);
      chk(lock, 1'b1);
      imm <= 3'b000;
      rdr(8'h08);
      chk(rd, 32'd6 + i);
      remote <= 1'b1;
      repeat (200 * T) @(posedge clock_i);
      remote <= 1'b0;
      repeat (4) @(posedge clock_i);
      chk(lock, 1'b0);
    end
    end_of_test;
  end
endmodule

// ---- hw/menu_lockout.sv ----
// Push-button programming menu, lockout classification and LED drive.
`timescale 1ns/1ps
`include "menu_defines.svh"
module menu_lockout
  import menu_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `CLK_HZ / `TICK_HZ
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        button_i,
  input  wire logic        remote_reset_i,
  input  wire logic        running_i,
  input  wire logic        flame_i,
  input  wire logic        flame_loss_i,
  input  wire logic        oil_valve_open_i,
  input  wire logic        heater_fitted_i,
  input  wire logic        preheating_i,
  input  wire logic        light_standby_i,
  input  wire logic        light_prepurge_i,
  input  wire logic        light_preheat_i,
  input  wire logic        fan_fault_i,
  input  wire logic        valve_drive_fault_i,
  input  wire logic        nvm_error_i,
  output logic             led_red_o,
  output logic             led_green_o,
  output logic             shutdown_req_o,
  output logic             recycle_restore_o,
  output logic             restart_req_o,
  output logic             lockout_o,
  output logic             pb_fail_o,
  output logic             light_diag_en_o,
  output logic [1:0]       interm_mode_o
);

  function automatic logic in_win(input logic [19:0] t, input logic [19:0] lo,
                                  input logic [19:0] hi);
    in_win = (t >= lo) && (t < hi);
  endfunction

  logic [15:0] tick_cnt_reg;
  logic        tick_reg;
  logic        btn_q_reg;
  logic [19:0] hold_ms_reg;
  logic [19:0] timer_ms_reg;
  logic [19:0] light_ms_reg;
  logic [19:0] preheat_ms_reg;
  logic [19:0] noflame_ms_reg;
  state_t      st_reg;
  logic        page_int_reg;
  logic [1:0]  val_cnt_reg;
  logic        pb_fail_reg;
  logic        lockout_reg;
  cause_t      cause_reg;
  cause_t      last_cause_reg;
  logic        light_en_reg;
  interm_t     interm_pend_reg;
  interm_t     interm_act_reg;
  logic [3:0]  blink_left_reg;
  logic [9:0]  blink_ms_reg;
  logic        blink_red_reg;
  logic        blink_slow_reg;
  logic [9:0]  pat_ms_reg;
  logic [4:0]  pat_half_reg;
  logic        led_red_reg;
  logic        led_green_reg;
  logic        shutdown_reg;
  logic        restart_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic        wstrb0_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  // Local and remote contacts act as one reset input.
  wire logic btn     = button_i | remote_reset_i;
  wire logic press   = btn & ~btn_q_reg;
  wire logic release_ev = ~btn & btn_q_reg;
  wire logic hold_inc = btn & tick_reg & (hold_ms_reg != `PB_FAIL_MS);
  wire logic pb_trip = btn & ~pb_fail_reg & (hold_ms_reg == `PB_FAIL_MS);
  wire logic win_shut = in_win(hold_ms_reg, `HOLD_SHUT_LO_MS, `HOLD_SHUT_HI_MS);
  wire logic win_diag = in_win(hold_ms_reg, `HOLD_DIAG_LO_MS, `HOLD_DIAG_HI_MS);
  wire logic win_int  = in_win(hold_ms_reg, `HOLD_INT_LO_MS, `HOLD_INT_HI_MS);
  wire logic win_lock = in_win(hold_ms_reg, `HOLD_LOCK_LO_MS, `HOLD_LOCK_HI_MS);
  wire logic [1:0] val_max = page_int_reg ? 2'h3 : 2'h2;
  wire logic idle_done = (st_reg == ST_SET) & tick_reg & ~btn
                       & (timer_ms_reg == `MENU_IDLE_MS - 20'h1);
  wire logic show_done = (st_reg == ST_SHOWL) & tick_reg & ~press
                       & (timer_ms_reg == `LOCK_SHOW_MS - 20'h1);
  // Stored value after the idle timeout; no press keeps the old one.
  wire logic     light_new  = (val_cnt_reg == 2'h0) ? light_en_reg : (val_cnt_reg == 2'h1);
  wire interm_t  interm_new = (val_cnt_reg == 2'h0) ? interm_pend_reg
                            : interm_t'(val_cnt_reg - 2'h1);
  wire logic [2:0] value_blinks = page_int_reg ? {1'b0, interm_new} + 3'h1
                                : (light_new ? 3'h1 : 3'h2);
  // Page announcement starts as the hold crosses each window's lower edge.
  wire logic ann_tick = (st_reg == ST_HOLD) & hold_inc;
  wire blink_t page_blink = '{start: ann_tick & ((hold_ms_reg == `HOLD_SHUT_LO_MS - 20'h1)
                              | (hold_ms_reg == `HOLD_DIAG_LO_MS - 20'h1)
                              | (hold_ms_reg == `HOLD_INT_LO_MS - 20'h1)
                              | (hold_ms_reg == `HOLD_LOCK_LO_MS - 20'h1)),
                              count: (hold_ms_reg < `HOLD_INT_LO_MS - 20'h1) ? 3'h2
                                   : (hold_ms_reg < `HOLD_LOCK_LO_MS - 20'h1) ? 3'h3 : 3'h4,
                              red: hold_ms_reg < `HOLD_DIAG_LO_MS - 20'h1, slow: 1'b0};
  wire blink_t value_blink = '{start: idle_done, count: value_blinks, red: 1'b0, slow: 1'b1};
  wire blink_t blink_go = page_blink.start ? page_blink : value_blink;
  wire logic [9:0] blink_half = blink_slow_reg ? `VALUE_HALF_MS : `PAGE_HALF_MS;
  wire logic blink_lit = (blink_left_reg != 4'h0) & ~blink_left_reg[0];
  // Lockout causes; the first one seen is kept until the operator resets.
  wire logic light_any = light_standby_i | light_prepurge_i | light_preheat_i;
  wire logic light_trip = tick_reg & light_any & (light_ms_reg == `LIGHT_LOCK_MS - 20'h1);
  wire logic heat_trip = tick_reg & heater_fitted_i & preheating_i
                       & (preheat_ms_reg == `PREHEAT_LOCK_MS - 20'h1);
  wire logic flame_trip = tick_reg & oil_valve_open_i & ~flame_i
                        & (noflame_ms_reg == `NOFLAME_LOCK_MS - 20'h1);
  wire cause_t lock_cause = fan_fault_i ? CAUSE_FAN
                          : valve_drive_fault_i ? CAUSE_VALVE_DRIVE
                          : nvm_error_i ? CAUSE_NVM
                          : flame_trip ? CAUSE_NO_FLAME
                          : heat_trip ? CAUSE_PREHEAT_TMO
                          : !light_trip ? CAUSE_NONE
                          : light_standby_i ? CAUSE_LIGHT_STBY
                          : light_prepurge_i ? CAUSE_LIGHT_PURGE : CAUSE_LIGHT_HEAT;
  wire logic lock_event = ~lockout_reg & (lock_cause != CAUSE_NONE);
  wire logic lock_clear = lockout_reg & release_ev & ~pb_fail_reg;
  wire logic apply_interm = shutdown_reg | flame_loss_i;
  // Lockout pattern: red blinks as many times as the cause code, then a pause; the no-flame cause shows steady red.
  wire cause_t shown = lockout_reg ? cause_reg : last_cause_reg;
  wire logic [4:0] pat_len = {shown, 1'b0} + 5'h4;
  wire logic pat_red = (shown == CAUSE_NO_FLAME)
                     | ((pat_half_reg < {shown, 1'b0}) & ~pat_half_reg[0]);
  wire logic led_red_next = pb_fail_reg ? ~pat_half_reg[0]
                          : (lockout_reg | st_reg == ST_SHOWL) ? pat_red
                          : blink_lit & blink_red_reg;
  wire logic led_green_next = ~lockout_reg & ~pb_fail_reg
                            & ((st_reg == ST_SET) ? btn : blink_lit & ~blink_red_reg);
  wire logic do_write = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire logic set_hit = awaddr_reg == `ADDR_SETTINGS;
  wire logic [31:0] rd_word = (s_axi_araddr_i == `ADDR_SETTINGS)
                            ? {29'h0, interm_pend_reg, light_en_reg}
                            : (s_axi_araddr_i == `ADDR_STATUS)
                            ? {17'h0, st_reg, cause_reg, interm_act_reg, pb_fail_reg, lockout_reg}
                            : {28'h0, last_cause_reg};
  wire logic rd_ok = (s_axi_araddr_i == `ADDR_SETTINGS) | (s_axi_araddr_i == `ADDR_STATUS)
                   | (s_axi_araddr_i == `ADDR_LAST_LOCK);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= tick_cnt_reg == 16'(TICK_CYCLES - 1);
      tick_cnt_reg <= (tick_cnt_reg == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt_reg + 16'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      btn_q_reg      <= 1'b0;
      hold_ms_reg    <= 20'h0;
      pb_fail_reg    <= 1'b0;
      restart_reg    <= 1'b0;
      light_ms_reg   <= 20'h0;
      preheat_ms_reg <= 20'h0;
      noflame_ms_reg <= 20'h0;
    end else begin
      btn_q_reg      <= btn;
      hold_ms_reg    <= press ? 20'h0 : hold_ms_reg + {19'h0, hold_inc};
      pb_fail_reg    <= pb_trip | (pb_fail_reg & btn);
      restart_reg    <= pb_trip & ~lockout_reg;
      light_ms_reg   <= (light_any & ~lockout_reg) ? light_ms_reg + {19'h0, tick_reg} : 20'h0;
      preheat_ms_reg <= (heater_fitted_i & preheating_i & ~lockout_reg)
                        ? preheat_ms_reg + {19'h0, tick_reg} : 20'h0;
      noflame_ms_reg <= (oil_valve_open_i & ~flame_i & ~lockout_reg)
                        ? noflame_ms_reg + {19'h0, tick_reg} : 20'h0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lockout_reg    <= 1'b0;
      cause_reg      <= CAUSE_NONE;
      last_cause_reg <= CAUSE_NONE;
    end else begin
      lockout_reg    <= lock_event | (lockout_reg & ~lock_clear);
      cause_reg      <= lock_event ? lock_cause : cause_reg;
      last_cause_reg <= lock_event ? lock_cause : last_cause_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_reg       <= ST_IDLE;
      page_int_reg <= 1'b0;
      val_cnt_reg  <= 2'h0;
      timer_ms_reg <= 20'h0;
      shutdown_reg <= 1'b0;
    end else begin
      shutdown_reg <= 1'b0;
      if (pb_trip || lock_event) begin
        st_reg <= pb_trip ? ST_PBF : ST_IDLE;
      end else begin
        unique case (st_reg)
          ST_IDLE: if (press && running_i && !lockout_reg) st_reg <= ST_HOLD;
          ST_HOLD: if (release_ev) begin
            timer_ms_reg <= 20'h0;
            val_cnt_reg  <= 2'h0;
            page_int_reg <= win_int;
            st_reg       <= win_shut ? ST_SHUT : (win_diag | win_int) ? ST_SET
                          : win_lock ? ST_SHOWL : ST_IDLE;
          end
          ST_SHUT: if (blink_left_reg == 4'h0) begin
            shutdown_reg <= 1'b1;
            st_reg       <= ST_IDLE;
          end
          ST_SET: begin
            if (press && val_cnt_reg != val_max) val_cnt_reg <= val_cnt_reg + 2'h1;
            if (btn) timer_ms_reg <= 20'h0;
            else timer_ms_reg <= timer_ms_reg + {19'h0, tick_reg};
            if (idle_done) st_reg <= ST_SHOWV;
          end
          ST_SHOWV: if (blink_left_reg == 4'h0) st_reg <= ST_IDLE;
          ST_SHOWL: begin
            timer_ms_reg <= press ? 20'h0 : timer_ms_reg + {19'h0, tick_reg};
            if (show_done) st_reg <= ST_IDLE;
          end
          ST_PBF: if (!btn) st_reg <= ST_IDLE;
          default: st_reg <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      light_en_reg    <= `LIGHT_EN_RST;
      interm_pend_reg <= interm_t'(`INTERM_RST);
      interm_act_reg  <= interm_t'(`INTERM_RST);
    end else begin
      if (idle_done && !page_int_reg) light_en_reg <= light_new;
      if (idle_done && page_int_reg) interm_pend_reg <= interm_new;
      if (do_write && set_hit && wstrb0_reg) begin
        light_en_reg    <= wdata_reg[0];
        interm_pend_reg <= (wdata_reg[2:1] == 2'h3) ? INTERM_24H : interm_t'(wdata_reg[2:1]);
      end
      if (apply_interm) interm_act_reg <= interm_pend_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      blink_left_reg <= 4'h0;
      blink_ms_reg   <= 10'h000;
      blink_red_reg  <= 1'b0;
      blink_slow_reg <= 1'b0;
    end else if (blink_go.start) begin
      blink_left_reg <= {blink_go.count, 1'b0};
      blink_ms_reg   <= 10'h000;
      blink_red_reg  <= blink_go.red;
      blink_slow_reg <= blink_go.slow;
    end else if (tick_reg && blink_left_reg != 4'h0) begin
      blink_ms_reg   <= (blink_ms_reg == blink_half - 10'h1) ? 10'h000 : blink_ms_reg + 10'h1;
      if (blink_ms_reg == blink_half - 10'h1) blink_left_reg <= blink_left_reg - 4'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pat_ms_reg    <= 10'h000;
      pat_half_reg  <= 5'h00;
      led_red_reg   <= 1'b0;
      led_green_reg <= 1'b0;
    end else begin
      if (tick_reg) pat_ms_reg <= (pat_ms_reg == `VALUE_HALF_MS - 10'h1) ? 10'h000
                                  : pat_ms_reg + 10'h1;
      if (tick_reg && pat_ms_reg == `VALUE_HALF_MS - 10'h1)
        pat_half_reg <= (pat_half_reg >= pat_len - 5'h1) ? 5'h00 : pat_half_reg + 5'h1;
      led_red_reg   <= led_red_next;
      led_green_reg <= led_green_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb0_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && awready_reg) begin
        awaddr_reg  <= s_axi_awaddr_i;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_reg) begin
        wdata_reg  <= s_axi_wdata_i;
        wstrb0_reg <= s_axi_wstrb_i[0];
        wready_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (set_hit || awaddr_reg == `ADDR_STATUS || awaddr_reg == `ADDR_LAST_LOCK)
                      ? `RESP_OKAY : `RESP_DECERR;
      end
      if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else if (s_axi_arvalid_i && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= rd_ok ? `RESP_OKAY : `RESP_DECERR;
      rdata_reg   <= rd_ok ? rd_word : 32'h0000_0000;
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready_o   = awready_reg;
  assign s_axi_wready_o    = wready_reg;
  assign s_axi_bvalid_o    = bvalid_reg;
  assign s_axi_bresp_o     = bresp_reg;
  assign s_axi_arready_o   = arready_reg;
  assign s_axi_rvalid_o    = rvalid_reg;
  assign s_axi_rresp_o     = rresp_reg;
  assign s_axi_rdata_o     = rdata_reg;
  assign led_red_o         = led_red_reg;
  assign led_green_o       = led_green_reg;
  assign shutdown_req_o    = shutdown_reg;
  assign recycle_restore_o = shutdown_reg;
  assign restart_req_o     = restart_reg;
  assign lockout_o         = lockout_reg;
  assign pb_fail_o         = pb_fail_reg;
  assign light_diag_en_o   = light_en_reg;
  assign interm_mode_o     = interm_act_reg;

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  menu_entry_a: assert property ((st_reg == ST_HOLD && $past(st_reg) == ST_IDLE)
    |-> $past(running_i && !lockout_reg)) else $error("Menu entered outside operation.");
  count_sat_a: assert property ((st_reg == ST_SET && press && val_cnt_reg == val_max
    && !pb_trip && !lock_event) |=> val_cnt_reg == $past(val_max))
    else $error("Press count wrapped past maximum.");
  pb_fail_a: assert property ($rose(pb_fail_reg) |-> $past(hold_ms_reg) == `PB_FAIL_MS
    && restart_reg == !$past(lockout_reg)) else $error("Push-button failure timing wrong.");
  shut_exit_a: assert property (shutdown_reg |-> recycle_restore_o && blink_left_reg == 4'h0
    && st_reg == ST_IDLE) else $error("Shutdown test exit wrong.");
  green_follow_a: assert property (($past(st_reg) == ST_SET && !$past(lockout_reg)
    && !$past(pb_fail_reg)) |-> led_green_reg == $past(btn))
    else $error("Green LED does not follow the button.");
  idle_exit_a: assert property (idle_done && !pb_trip && !lock_event
    |=> st_reg == ST_SHOWV && blink_left_reg != 4'h0) else $error("Menu idle exit missed.");
  interm_apply_a: assert property ($changed(interm_act_reg) |-> $past(apply_interm))
    else $error("Intermittent setting applied early.");
  show_extend_a: assert property ((st_reg == ST_SHOWL && press && !pb_trip
    && !lock_event) |=> st_reg == ST_SHOWL && timer_ms_reg == 20'h0)
    else $error("Lockout display not extended.");
  lock_cause_a: assert property (lock_event |=> lockout_reg
    && last_cause_reg == $past(lock_cause) ##1 last_cause_reg == $past(lock_cause, 2))
    else $error("Lockout cause not recorded.");
  lock_leave_a: assert property ($fell(lockout_reg) |-> $past(release_ev))
    else $error("Lockout left without a press.");

endmodule

// ---- inc/menu_defines.svh ----
// Timing, address and reset constants for the push-button menu block.
`ifndef MENU_DEFINES_SVH
`define MENU_DEFINES_SVH

`define CLK_HZ          40000000
`define TICK_HZ         1000
`define HOLD_SHUT_LO_MS 20'h01388
`define HOLD_SHUT_HI_MS 20'h02710
`define HOLD_DIAG_LO_MS 20'h03A98
`define HOLD_DIAG_HI_MS 20'h04E20
`define HOLD_INT_LO_MS  20'h04E20
`define HOLD_INT_HI_MS  20'h061A8
`define HOLD_LOCK_LO_MS 20'h061A8
`define HOLD_LOCK_HI_MS 20'h07530
`define PB_FAIL_MS      20'h0EA60
`define MENU_IDLE_MS    20'h02710
`define LOCK_SHOW_MS    20'h02710
`define LIGHT_LOCK_MS   20'h061A8
`define PREHEAT_LOCK_MS 20'h927C0
`define NOFLAME_LOCK_MS 20'h01388
`define PAGE_HALF_MS    10'h0C8
`define VALUE_HALF_MS   10'h1F4
`define ADDR_SETTINGS   8'h00
`define ADDR_STATUS     8'h04
`define ADDR_LAST_LOCK  8'h08
`define LIGHT_EN_RST    1'b0
`define INTERM_RST      2'h2
`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3

`endif

// ---- inc/menu_pkg.sv ----
// Types shared by the push-button menu block.
package menu_pkg;

  typedef enum logic [3:0] {
    CAUSE_NONE        = 4'h0,
    CAUSE_LIGHT_STBY  = 4'h1,
    CAUSE_PREHEAT_TMO = 4'h2,
    CAUSE_LIGHT_PURGE = 4'h3,
    CAUSE_LIGHT_HEAT  = 4'h4,
    CAUSE_NO_FLAME    = 4'h5,
    CAUSE_FAN         = 4'h6,
    CAUSE_VALVE_DRIVE = 4'h7,
    CAUSE_NVM         = 4'h8
  } cause_t;

  typedef enum logic [1:0] {
    INTERM_OFF = 2'h0,
    INTERM_1H  = 2'h1,
    INTERM_24H = 2'h2
  } interm_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_HOLD  = 7'h02,
    ST_SHUT  = 7'h04,
    ST_SET   = 7'h08,
    ST_SHOWV = 7'h10,
    ST_SHOWL = 7'h20,
    ST_PBF   = 7'h40
  } state_t;

  typedef struct packed {
    logic       start;
    logic [2:0] count;
    logic       red;
    logic       slow;
  } blink_t;

endpackage
